// ==== ddc_channel_datapath.sv ====
// Contract
// R1 - Any selected input port is formatted into one 19-bit internal sample.
// R2 - Input selector at control index 27: values 0..3 pick ports A..D.
// R3 - CIC decimates by a programmable integer from 8 to 4096.
// R4 - Coarse gain after CIC shifts left by 0 to 7 bits.
// R5 - First FIR: symmetric 21 taps, decimate by two, 12 coefficient words.
// R6 - Second FIR: symmetric 63 taps, decimate by two, 32 coefficient words.
// R7 - Software must load both coefficient sets; none exist after power-up.
// R8 - Real-only mode keeps only the real mixer part; CIC minimum becomes 4.
// R9 - Decimation timing can be offset to interleave two or four channels.
// R10 - Complex-to-real makes the second FIR emit real data at double rate.
// R11 - Resampler outputs are spaced R input periods; interpolates or decimates.
// R12 - Resampling ratio is 32-bit unsigned, 6 integer and 26 fraction bits.
// R13 - Output instants use a programmable grid down to 1/64 input period.
// R14 - Final shifter moves output left by up to 15 bits.
// R15 - Output word rounds to 12, 16, 20 or 24 bits.
// R16 - Pad enable inserts 0 to 15 zero samples between input samples.
// R17 - Pad count and pad enable sit at control index 19.
// R18 - Pad sync selector picks the aligning event; 3 is sync pin B.
// R19 - A TDM source must time sync B to capture the wanted slot.
// R20 - Zero padding scales the signal by one over one plus count.
// R21 - Wide mixer rounding forces a CIC pre-shift of at least 4.
// R22 - Software should leave the CIC pre-shift at 4 normally.
// R23 - Tuning word is 32 bits and phase offset 16 bits.
// R24 - 14- and 16-bit words sit in the top bits; low bits cleared.
// R25 - One step per clock; padding zeros are ordinary samples.
// R26 - Resampler phase accumulator adds the ratio per output.
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module halfband_fir #(
  parameter int TAPS  = 21,
  parameter int WORDS = 12
) (
  input  logic                    clock_i,
  input  logic                    rst_n_i,
  input  logic [WORDS-1:0][15:0]  coef_i,
  input  logic                    decim_i,
  input  logic                    in_valid_i,
  input  logic signed [19:0]      in_data_i,
  output logic                    out_valid_o,
  output logic signed [19:0]      out_data_o
);

  typedef struct packed {
    logic [TAPS-2:0][19:0] h;
    logic                  ph;
    logic                  v;
    logic [19:0]           y;
  } fir_st_t;

  fir_st_t            q;
  fir_st_t            d;
  logic signed [47:0] acc;

  // Symmetric MAC over the history; the mirrored half reuses words.
  always_comb begin
    d = q;
    acc = 48'($signed(in_data_i) * $signed(coef_i[0]));
    for (int k = 1; k < TAPS; k++) begin
      acc = acc + 48'($signed(q.h[k-1]) * $signed(coef_i[k < (TAPS + 1) / 2 ? k : TAPS - 1 - k]));
    end
    d.v = 1'b0;
    if (in_valid_i) begin
      d.h  = {q.h[TAPS-3:0], in_data_i};
      d.ph = ~q.ph;
      d.v  = ~decim_i | q.ph;
      d.y  = ddc_pkg::sat20(64'(acc >>> 16));
    end
  end

  // State register.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign out_valid_o = q.v;
  assign out_data_o  = q.y;

endmodule // halfband_fir

module ddc_channel_datapath (
  input  logic                  clock_i,
  input  logic                  rst_n_i,
  input  logic                  wb_cyc_i,
  input  logic                  wb_stb_i,
  input  logic                  wb_we_i,
  input  logic [31:0]           wb_adr_i,
  input  logic [3:0]            wb_sel_i,
  input  logic [31:0]           wb_dat_i,
  output logic [31:0]           wb_dat_o,
  output logic                  wb_ack_o,
  input  ddc_pkg::sample_ports_t samp_ports_i,
  input  logic                  input_sync_b_n_i,
  output ddc_pkg::out_sample_t  out_o
);

  typedef struct packed {
    ddc_pkg::cfg_t           r;
    logic [11:0][15:0]       cf;
    logic [31:0][15:0]       pf;
    logic                    ack;
    logic [31:0]             dat;
    logic                    sw;
    ddc_pkg::sample_ports_t  p1;
    ddc_pkg::sample_ports_t  p2;
    logic                    sb1;
    logic                    sb2;
    logic                    sb3;
    logic [3:0]              pc;
    logic [18:0]             xs;
    logic [31:0]             nco;
    logic [1:0][19:0]        m;
    logic [1:0][4:0][79:0]   ig;
    logic [1:0][4:0][79:0]   dl;
    logic [12:0]             dc;
    logic                    cv;
    logic [1:0][19:0]        c;
    logic                    gv;
    logic [1:0][19:0]        g;
    logic                    rot;
    logic                    hv;
    logic [1:0][19:0]        rp;
    logic [1:0][19:0]        rc;
    logic [1:0]              prim;
    logic [31:0]             acc;
    ddc_pkg::out_sample_t    o;
    logic [15:0]             cnt;
  } st_t;

  st_t                   q;
  st_t                   d;
  logic [6:0]            idx;
  logic                  req;
  logic                  sync_ev;
  logic [3:0]            pc_eff;
  logic [18:0]           fmt;
  logic [15:0]           port;
  logic signed [19:0]    x20;
  logic [1:0][19:0]      mr;
  logic [15:0]           ph;
  logic [12:0]           mn;
  logic [12:0]           n_eff;
  logic [12:0]           ofs;
  logic [2:0]            sh_eff;
  logic [1:0][5:0][79:0] kc;
  logic [1:0]            fv;
  logic [1:0][19:0]      fy;
  logic [1:0]            pv;
  logic [1:0][19:0]      py;
  logic                  c2r;
  logic                  rv;
  logic [1:0][19:0]      rin;
  logic                  emit;
  logic [2:0]            gbits;
  logic [26:0]           rnd;
  logic [6:0]            fq;
  logic [32:0]           anx;
  logic [19:0]           y;
  logic [23:0]           w;
  logic [4:0]            drop;

  // ---------------------------------------------------------------
  // Filter pair per path: the first decimates by two, the second also unless complex-to-real is set.
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    halfband_fir #(.TAPS(21), .WORDS(12)) u_first_halfband_fir ( // R5
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .coef_i      (q.cf),
      .decim_i     (1'b1),
      .in_valid_i  (q.gv),
      .in_data_i   (q.g[ch]),
      .out_valid_o (fv[ch]),
      .out_data_o  (fy[ch])
    );
    halfband_fir #(.TAPS(63), .WORDS(32)) u_second_shaping_fir ( // R6
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .coef_i      (q.pf),
      .decim_i     (~c2r), // R10
      .in_valid_i  (fv[ch]),
      .in_data_i   (fy[ch]),
      .out_valid_o (pv[ch]),
      .out_data_o  (py[ch])
    );
  end

  // ---------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    // Wishbone slave with a one-cycle registered acknowledge.
    idx = wb_adr_i[8:2];
    req = wb_cyc_i & wb_stb_i & ~q.ack;
    d.ack = req;
    d.sw = 1'b0;
    if (req) begin
      d.dat = '0;
      if (wb_we_i) begin
        case (idx)
          ddc_pkg::REG_SHIFT:  d.r.shift = ddc_pkg::wm(q.r.shift, wb_dat_i, wb_sel_i) & ddc_pkg::MSK_3B;
          ddc_pkg::REG_ZPAD: begin
            d.r.zpad = ddc_pkg::wm(q.r.zpad, wb_dat_i, wb_sel_i) & ddc_pkg::MSK_ZPAD; // R17
            d.sw = 1'b1;
          end
          ddc_pkg::REG_DECIM:  d.r.decim = ddc_pkg::wm(q.r.decim, wb_dat_i, wb_sel_i) & ddc_pkg::MSK_DECIM;
          ddc_pkg::REG_MIX:    d.r.mix = ddc_pkg::wm(q.r.mix, wb_dat_i, wb_sel_i) & ddc_pkg::MSK_1B;
          ddc_pkg::REG_COARSE: d.r.coarse = ddc_pkg::wm(q.r.coarse, wb_dat_i, wb_sel_i) & ddc_pkg::MSK_3B;
          ddc_pkg::REG_INPUT:  d.r.inp = ddc_pkg::wm(q.r.inp, wb_dat_i, wb_sel_i) & ddc_pkg::MSK_3B; // R2
          ddc_pkg::REG_FREQ:   d.r.freq = ddc_pkg::wm(q.r.freq, wb_dat_i, wb_sel_i); // R23
          ddc_pkg::REG_PHASE:  d.r.phase = ddc_pkg::wm(q.r.phase, wb_dat_i, wb_sel_i) & ddc_pkg::MSK_16B;
          ddc_pkg::REG_RATIO:  d.r.ratio = ddc_pkg::wm(q.r.ratio, wb_dat_i, wb_sel_i); // R12
          ddc_pkg::REG_RES:    d.r.res = ddc_pkg::wm(q.r.res, wb_dat_i, wb_sel_i) & ddc_pkg::MSK_3B;
          ddc_pkg::REG_OUT:    d.r.outf = ddc_pkg::wm(q.r.outf, wb_dat_i, wb_sel_i) & ddc_pkg::MSK_OUT;
          ddc_pkg::REG_MODE:   d.r.mode = ddc_pkg::wm(q.r.mode, wb_dat_i, wb_sel_i) & ddc_pkg::MSK_MODE;
          default: begin
            if (idx >= ddc_pkg::REG_FIRST_HALFBAND_FIR && idx < ddc_pkg::REG_FIRST_HALFBAND_FIR + ddc_pkg::FIRST_HALFBAND_FIR_WORDS)
              d.cf[4'(idx - ddc_pkg::REG_FIRST_HALFBAND_FIR)] = 16'(ddc_pkg::wm({16'h0000, q.cf[4'(idx - ddc_pkg::REG_FIRST_HALFBAND_FIR)]},
                                                                 wb_dat_i, wb_sel_i));
            // The second bank runs to the top index, so only the lower bound is tested.
            if (idx >= ddc_pkg::REG_SECOND_SHAPING_FIR)
              d.pf[5'(idx - ddc_pkg::REG_SECOND_SHAPING_FIR)] = 16'(ddc_pkg::wm({16'h0000, q.pf[5'(idx - ddc_pkg::REG_SECOND_SHAPING_FIR)]},
                                                                 wb_dat_i, wb_sel_i));
          end
        endcase
      end else begin
        case (idx)
          ddc_pkg::REG_SHIFT:  d.dat = q.r.shift;
          ddc_pkg::REG_ZPAD:   d.dat = q.r.zpad;
          ddc_pkg::REG_DECIM:  d.dat = q.r.decim;
          ddc_pkg::REG_MIX:    d.dat = q.r.mix;
          ddc_pkg::REG_COARSE: d.dat = q.r.coarse;
          ddc_pkg::REG_INPUT:  d.dat = q.r.inp;
          ddc_pkg::REG_FREQ:   d.dat = q.r.freq;
          ddc_pkg::REG_PHASE:  d.dat = q.r.phase;
          ddc_pkg::REG_RATIO:  d.dat = q.r.ratio;
          ddc_pkg::REG_RES:    d.dat = q.r.res;
          ddc_pkg::REG_OUT:    d.dat = q.r.outf;
          ddc_pkg::REG_MODE:   d.dat = q.r.mode;
          ddc_pkg::REG_STAT:   d.dat = {16'h0000, q.cnt};
          default: begin
            if (idx >= ddc_pkg::REG_FIRST_HALFBAND_FIR && idx < ddc_pkg::REG_FIRST_HALFBAND_FIR + ddc_pkg::FIRST_HALFBAND_FIR_WORDS)
              d.dat = {16'h0000, q.cf[4'(idx - ddc_pkg::REG_FIRST_HALFBAND_FIR)]};
            if (idx >= ddc_pkg::REG_SECOND_SHAPING_FIR)
              d.dat = {16'h0000, q.pf[5'(idx - ddc_pkg::REG_SECOND_SHAPING_FIR)]};
          end
        endcase
      end
    end

    // Pin synchronisers; the second stage feeds logic, and sync B also uses the third for its edge.
    d.p1 = samp_ports_i;
    d.p2 = q.p1;
    d.sb1 = input_sync_b_n_i;
    d.sb2 = q.sb1;
    d.sb3 = q.sb2;

    // Pad sync source: software strobe or falling edge of sync B.
    case (q.r.zpad[ddc_pkg::PAD_SYNC_SELECT_LSB+:2])
      ddc_pkg::SYNC_SW:  sync_ev = q.sw;
      ddc_pkg::SYNC_PIN: sync_ev = ~q.sb2 & q.sb3; // R18
      default:           sync_ev = 1'b0;
    endcase

    // Input formatting: 14- or 16-bit words placed in the top bits.
    port = q.p2[q.r.inp[1:0]]; // R2
    fmt = q.r.inp[ddc_pkg::INPUT_W14_BIT] ? {port[13:0], 5'h00} : {port, 3'h0}; // R24

    // Zero padding: a sample every count+1 clocks, zeros between.
    pc_eff = sync_ev ? 4'h0 : q.pc;
    d.pc = (pc_eff >= q.r.zpad[3:0]) ? 4'h0 : pc_eff + 4'h1;
    d.xs = (!q.r.zpad[ddc_pkg::PAD_ENABLE_BIT] || pc_eff == 4'h0) ? fmt : 19'h0_0000; // R1 R16 R20 R25

    // Oscillator and quadrant mixer with selectable rounding.
    d.nco = q.nco + q.r.freq; // R23
    ph = q.nco[31:16] + q.r.phase[15:0];
    x20 = $signed({q.xs, 1'b0});
    case (ph[15:14])
      2'h0:    mr = {20'h0_0000, x20};
      2'h1:    mr = {ddc_pkg::sat20(-64'(x20)), 20'h0_0000};
      2'h2:    mr = {20'h0_0000, ddc_pkg::sat20(-64'(x20))};
      default: mr = {x20, 20'h0_0000};
    endcase
    for (int ch = 0; ch < 2; ch++) begin
      d.m[ch] = q.r.mix[0] ? mr[ch] : ddc_pkg::sat20(((64'($signed(mr[ch])) + 64'sh8) >>> 4) <<< 4);
    end
    if (q.r.mode[ddc_pkg::MODE_REAL_BIT]) d.m[1] = '0; // R8

    // CIC decimation factor clamp and pre-shift floor.
    mn = q.r.mode[ddc_pkg::MODE_REAL_BIT] ? ddc_pkg::DECIM_MIN_REAL : ddc_pkg::DECIM_MIN; // R8
    n_eff = (q.r.decim[12:0] < mn) ? mn : (q.r.decim[12:0] > ddc_pkg::DECIM_MAX) ? ddc_pkg::DECIM_MAX
          : q.r.decim[12:0]; // R3
    sh_eff = (q.r.mix[0] && q.r.shift[2:0] < ddc_pkg::SHIFT_MIN_WIDE) ? ddc_pkg::SHIFT_MIN_WIDE
           : q.r.shift[2:0]; // R21
    ofs = {1'b0, q.r.mode[ddc_pkg::MODE_OFS_LSB+:12]};
    if (sync_ev) d.dc = (ofs < n_eff) ? ofs : 13'h0000; // R9
    else d.dc = (q.dc >= n_eff - 13'h0001) ? 13'h0000 : q.dc + 13'h0001;

    // Five integrators every clock, five combs at the decimated rate.
    d.cv = (q.dc == 13'h0000);
    for (int ch = 0; ch < 2; ch++) begin
      d.ig[ch][0] = q.ig[ch][0] + 80'($signed(q.m[ch]));
      for (int k = 1; k < 5; k++) d.ig[ch][k] = q.ig[ch][k] + q.ig[ch][k-1];
      kc[ch][0] = q.ig[ch][4];
      for (int k = 0; k < 5; k++) kc[ch][k+1] = kc[ch][k] - q.dl[ch][k];
      if (d.cv) begin
        for (int k = 0; k < 5; k++) d.dl[ch][k] = kc[ch][k];
        d.c[ch] = ddc_pkg::sat20(64'($signed(kc[ch][5]) >>> (ddc_pkg::CIC_SHIFT_BASE - 7'(sh_eff))));
      end
      // Coarse gain with saturation.
      d.g[ch] = ddc_pkg::sat20(64'($signed(q.c[ch])) <<< q.r.coarse[2:0]); // R4
    end
    d.gv = q.cv;

    // Complex-to-real: one real sample per undecimated input, cycling I,-Q,-I,Q.
    c2r = q.r.mode[ddc_pkg::MODE_C2R_BIT];
    rin = py;
    rv = pv[0];
    if (c2r) begin // R10
      rin[1] = '0;
      case ({q.hv, q.rot})
        2'h0:    rin[0] = py[0];
        2'h1:    rin[0] = ddc_pkg::sat20(-64'($signed(py[1])));
        2'h2:    rin[0] = ddc_pkg::sat20(-64'($signed(py[0])));
        default: rin[0] = py[1];
      endcase
      if (pv[0]) {d.hv, d.rot} = {q.hv, q.rot} + 2'h1;
    end

    // Resampler: phase accumulator in 6.26 time since the older sample.
    emit = (q.prim == 2'h2) && (q.acc[31:26] == 6'h00); // R11
    gbits = (q.r.res[2:0] > 3'h6) ? 3'h6 : q.r.res[2:0];
    rnd = {1'b0, q.acc[25:0]} + (27'h1 << (5'd25 - 5'(gbits)));
    fq = 7'((rnd >> (5'd26 - 5'(gbits))) << (3'h6 - gbits)); // R13
    anx = {1'b0, q.acc} + (emit ? {1'b0, q.r.ratio} : 33'h0_0000_0000); // R26
    if (rv) begin
      anx = (anx >= ddc_pkg::RATIO_ONE) ? anx - ddc_pkg::RATIO_ONE : 33'h0_0000_0000;
      d.rp = q.rc;
      d.rc = rin;
      d.prim = (q.prim == 2'h2) ? 2'h2 : q.prim + 2'h1;
    end
    d.acc = anx[31:0];

    // Interpolate, shift and round each path into the output word.
    drop = 5'(5'd12 - {1'b0, q.r.outf[ddc_pkg::OUT_WID_LSB+:2], 2'b00});
    d.o.valid = emit;
    w = '0;
    y = '0;
    for (int ch = 0; ch < 2; ch++) begin
      y = ddc_pkg::sat20(64'($signed(q.rp[ch])) + (((64'($signed(q.rc[ch])) - 64'($signed(q.rp[ch])))
          * $signed(64'(fq))) >>> 6));
      w = ddc_pkg::sat24(64'($signed(y)) <<< q.r.outf[3:0]); // R14
      w = ddc_pkg::sat24(64'($signed(w)) + ((drop == 5'h00) ? 64'h0 : (64'h1 << (drop - 5'h01))));
      w = w & ~((24'h00_0001 << drop) - 24'h00_0001); // R15
      if (emit) begin
        if (ch == 0) d.o.i = w;
        else d.o.q = w;
      end
    end
    if (emit) d.cnt = q.cnt + 16'h0001;
  end

  // ---------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.r.shift <= ddc_pkg::SHIFT_RST;
      q.r.decim <= ddc_pkg::DECIM_RST;
      q.r.mix <= ddc_pkg::MSK_1B;
      q.r.ratio <= ddc_pkg::RATIO_RST;
      q.r.res <= ddc_pkg::RES_RST;
      q.sb1 <= 1'b1;
      q.sb2 <= 1'b1;
      q.sb3 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign out_o    = q.o;

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  AST_FORMAT: assert property (!q.r.zpad[ddc_pkg::PAD_ENABLE_BIT] |=> q.xs == $past(fmt)) // R24
    else $error("Formatted sample does not follow the selected port.");
  AST_PAD_ZERO: assert property (q.r.zpad[ddc_pkg::PAD_ENABLE_BIT] && q.pc != 4'h0 && !sync_ev |=> q.xs == '0) // R16
    else $error("Padding slot did not carry a zero sample.");
  AST_DECIM_RANGE: assert property ((q.dc < n_eff || $changed(n_eff)) && n_eff >= 13'h0004 && n_eff <= 13'h1000) // R3
    else $error("Decimation counter outside the factor range.");
  AST_ALIGN: assert property (sync_ev && ofs < n_eff |=> q.dc == $past(ofs)) // R9
    else $error("Decimation phase did not load the offset on sync.");
  AST_PRESHIFT: assert property (q.r.mix[0] |-> sh_eff >= 3'h4) // R21
    else $error("Pre-shift below four with wide mixer rounding.");
  AST_REAL: assert property (q.r.mode[ddc_pkg::MODE_REAL_BIT] |=> q.m[1] == '0) // R8
    else $error("Imaginary path active in real-only mode.");
  AST_COARSE: assert property (q.cv && q.r.coarse[2:0] == 3'h0 ##1 q.r.coarse[2:0] == 3'h0 |-> q.g[0] == $past(q.c[0])) // R4
    else $error("Zero coarse gain altered the CIC output.");
  AST_C2R: assert property (c2r && pv[0] |=> {q.hv, q.rot} == $past({q.hv, q.rot}) + 2'h1) // R10
    else $error("Complex-to-real sequence did not advance on a filter output.");
  AST_RS_STEP: assert property (emit && !rv |=> q.acc == $past(q.acc) + $past(q.r.ratio)) // R26
    else $error("Resampler phase did not advance by the ratio.");
  AST_ROUND: assert property (q.o.valid |-> (q.o.i & ((24'h00_0001 << drop) - 24'h00_0001)) == 24'h00_0000) // R15
    else $error("Output word not rounded to the selected width.");

endmodule // ddc_channel_datapath

// ==== ddc_pkg.sv ====
package ddc_pkg;

  // ---------------------------------------------------------------
  // Register indexes (byte address is four times the index).
  // ---------------------------------------------------------------
  localparam logic [6:0] REG_SHIFT  = 7'h10;
  localparam logic [6:0] REG_ZPAD   = 7'h13;
  localparam logic [6:0] REG_DECIM  = 7'h15;
  localparam logic [6:0] REG_MIX    = 7'h17;
  localparam logic [6:0] REG_COARSE = 7'h19;
  localparam logic [6:0] REG_INPUT  = 7'h1b;
  localparam logic [6:0] REG_FREQ   = 7'h20;
  localparam logic [6:0] REG_PHASE  = 7'h21;
  localparam logic [6:0] REG_RATIO  = 7'h22;
  localparam logic [6:0] REG_RES    = 7'h23;
  localparam logic [6:0] REG_OUT    = 7'h24;
  localparam logic [6:0] REG_MODE   = 7'h25;
  localparam logic [6:0] REG_STAT   = 7'h26;
  localparam logic [6:0] REG_FIRST_HALFBAND_FIR   = 7'h40;
  localparam logic [6:0] REG_SECOND_SHAPING_FIR   = 7'h60;
  localparam logic [6:0] FIRST_HALFBAND_FIR_WORDS = 7'h0c;
  localparam logic [6:0] SECOND_SHAPING_FIR_WORDS = 7'h20;

  // ---------------------------------------------------------------
  // Writable bit masks, field positions and reset values.
  // ---------------------------------------------------------------
  localparam logic [31:0] MSK_3B    = 32'h0000_0007;
  localparam logic [31:0] MSK_ZPAD  = 32'h0000_007f;
  localparam logic [31:0] MSK_DECIM = 32'h0000_1fff;
  localparam logic [31:0] MSK_1B    = 32'h0000_0001;
  localparam logic [31:0] MSK_16B   = 32'h0000_ffff;
  localparam logic [31:0] MSK_OUT   = 32'h0000_003f;
  localparam logic [31:0] MSK_MODE  = 32'h0000_fff3;
  localparam int PAD_ENABLE_BIT   = 4;
  localparam int PAD_SYNC_SELECT_LSB = 5;
  localparam int INPUT_W14_BIT = 2;
  localparam int MODE_REAL_BIT = 0;
  localparam int MODE_C2R_BIT  = 1;
  localparam int MODE_OFS_LSB  = 4;
  localparam int OUT_WID_LSB   = 4;
  localparam logic [31:0] SHIFT_RST = 32'h0000_0004;
  localparam logic [31:0] DECIM_RST = 32'h0000_0008;
  localparam logic [31:0] RATIO_RST = 32'h0400_0000;
  localparam logic [31:0] RES_RST   = 32'h0000_0006;
  localparam logic [12:0] DECIM_MIN      = 13'h0008;
  localparam logic [12:0] DECIM_MIN_REAL = 13'h0004;
  localparam logic [12:0] DECIM_MAX      = 13'h1000;
  localparam logic [2:0]  SHIFT_MIN_WIDE = 3'h4;
  localparam logic [6:0]  CIC_SHIFT_BASE = 7'h40;
  localparam logic [32:0] RATIO_ONE      = 33'h0_0400_0000;
  localparam logic [1:0]  SYNC_SW        = 2'h1;
  localparam logic [1:0]  SYNC_PIN       = 2'h3;

  typedef logic [3:0][15:0] sample_ports_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] i;
    logic [23:0] q;
  } out_sample_t;

  typedef struct packed {
    logic [31:0] shift;
    logic [31:0] zpad;
    logic [31:0] decim;
    logic [31:0] mix;
    logic [31:0] coarse;
    logic [31:0] inp;
    logic [31:0] freq;
    logic [31:0] phase;
    logic [31:0] ratio;
    logic [31:0] res;
    logic [31:0] outf;
    logic [31:0] mode;
  } cfg_t;

  // Byte-lane merge of a Wishbone write.
  function automatic logic [31:0] wm(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) o[8*b+:8] = n[8*b+:8];
    end
    return o;
  endfunction

  function automatic logic [19:0] sat20(input logic signed [63:0] x);
    if (x > 64'sh7_ffff) return 20'h7_ffff;
    if (x < -64'sh8_0000) return 20'h8_0000;
    return x[19:0];
  endfunction

  function automatic logic [23:0] sat24(input logic signed [63:0] x);
    if (x > 64'sh7f_ffff) return 24'h7f_ffff;
    if (x < -64'sh80_0000) return 24'h80_0000;
    return x[23:0];
  endfunction

endpackage

// ==== sample_source.sv ====
`timescale 1ns/1ps
// Far-side source: steady words on ports A..D, sync B low one clock in eight.
module sample_source (
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  output wire ddc_pkg::sample_ports_t ports_o,
  output wire logic                   sync_b_n_o
);
  logic [2:0] slot_q;
  // Slot counter of an eight-slot frame.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) slot_q <= 3'h0;
    else slot_q <= slot_q + 3'h1;
  end
  // Port A carries a DC level so the channel output is never idle.
  assign ports_o = {16'hc000, 16'h2000, 16'h1000, 16'h4000};
  // The strobe marks slot 0, the wanted TDM sample.
  assign sync_b_n_o = (slot_q != 3'h0);
endmodule // sample_source

// ==== testbench.sv ====
`timescale 1ns/1ps
`define CHK(a,b) begin checked++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t got %h want %h", $time, a, b); end end
module testbench;
  logic                   clock_i, rst_n_i, cyc, stb, we, ack, sync_n, q_seen;
  logic [31:0]            adr, dat, dat_o;
  ddc_pkg::sample_ports_t ports;
  ddc_pkg::out_sample_t   out;
  int                     n_mismatch, checked, n_out;
  // ---------------------------------------------------------------
  // Clock, partner, design and output counter.
  // ---------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  sample_source src (.clock_i(clock_i), .rst_n_i(rst_n_i), .ports_o(ports), .sync_b_n_o(sync_n));
  ddc_channel_datapath dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .samp_ports_i(ports), .input_sync_b_n_i(sync_n), .out_o(out));
  // Counts output pulses and notes any nonzero quadrature word.
  always @(negedge clock_i) begin
    if (out.valid === 1'b1) begin
      n_out++;
      if (out.q !== 24'h0) q_seen = 1'b1;
    end
  end
  // One Wishbone classic cycle; waits for ack, then releases for a cycle.
  task automatic wb(input logic w, input logic [6:0] i, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {23'h0, i, 2'h0};
    dat <= d;
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    `CHK(ack, 1'b1)
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [6:0] i, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, i, 32'h0, r);
    `CHK(r, e)
  endtask
  task automatic wr(input logic [6:0] i, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, i, d, r);
  endtask
  // Counts outputs over 3200 clocks after settling; counter reset off the edge.
  task automatic rate(input int lo, input int hi);
    repeat (400) @(negedge clock_i);
    n_out = 0;
    q_seen = 1'b0;
    repeat (3200) @(negedge clock_i);
    `CHK(n_out >= lo && n_out <= hi, 1'b1)
    @(posedge clock_i);
  endtask
  task automatic conclude;
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Stops a hung run.
  initial begin
    #2000000;
    n_mismatch++;
    conclude();
  end
  // Register checks, then output rates per setting.
  initial begin
    rst_n_i = 1'b0;
    {cyc, stb, we, adr, dat, n_mismatch, checked, n_out, q_seen} = '0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    rd(7'h10, 32'h0000_0004);
    rd(7'h15, 32'h0000_0008);
    rd(7'h17, 32'h0000_0001);
    rd(7'h22, 32'h0400_0000);
    rd(7'h01, 32'h0000_0000);
    wr(7'h13, 32'hffff_ffff);
    rd(7'h13, 32'h0000_007f);
    wr(7'h19, 32'hffff_ffff);
    rd(7'h19, 32'h0000_0007);
    wr(7'h21, 32'hffff_ffff);
    rd(7'h21, 32'h0000_ffff);
    wr(7'h24, 32'hffff_ffff);
    rd(7'h24, 32'h0000_003f);
    wr(7'h1b, 32'h0000_0003);
    rd(7'h1b, 32'h0000_0003);
    wr(7'h1b, 32'h0000_0000);
    wr(7'h13, 32'h0000_0000);
    wr(7'h21, 32'h0000_0000);
    for (int k = 0; k < 12; k++) wr(7'h40 + 7'(k), (k == 10) ? 32'h0000_7fff : 32'h0);
    for (int k = 0; k < 32; k++) wr(7'h60 + 7'(k), (k == 31) ? 32'h0000_7fff : 32'h0);
    rate(97, 103);
    wr(7'h15, 32'h0000_0004);
    rate(97, 103);
    wr(7'h15, 32'h0000_0010);
    rate(47, 53);
    wr(7'h22, 32'h0800_0000);
    rate(22, 28);
    wr(7'h22, 32'h0200_0000);
    rate(97, 103);
    wr(7'h22, 32'h0400_0000);
    wr(7'h13, 32'h0000_0073);
    rate(97, 103);
    wr(7'h25, 32'h0000_0002);
    rate(197, 203);
    `CHK(q_seen, 1'b0)
    wr(7'h25, 32'h0000_0001);
    wr(7'h15, 32'h0000_0004);
    rate(197, 203);
    `CHK(q_seen, 1'b0)
    conclude();
  end
endmodule // testbench
